// >>> acc_top.v
// Purpose: control and status registers for two analog comparators
// Assumes: raw results arrive asynchronously from the analog cores
// Notes:   flags clear by writing 1 to the flag register bit
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "acc_defines.vh"

module acc_top (
   input  wire                    REF_CLK,
   input  wire                    RESET,
   input  wire [`ACC_ADDR_W-1:0]  ADDR,
   input  wire [7:0]              WDATA,
   input  wire                    WR,
   input  wire                    RD,
   output reg  [7:0]              RDATA,
   input  wire [1:0]              RAW_CMP,
   input  wire                    CNT_CLK,
   output wire [1:0]              CMP_ENABLE,
   output wire [1:0]              CMP_DEADBAND,
   output wire [1:0]              CMP_TO_TIMER,
   output wire [1:0]              CMP_TO_PIN,
   output wire [1:0]              CMP_IRQ_FLAG,
   output wire [7:0]              MINUS_ROUTE1,
   output wire [7:0]              MINUS_ROUTE2,
   output wire [7:0]              PLUS_ROUTE1,
   output wire [7:0]              PLUS_ROUTE2
);

   ////////////////////////////////////////////////////////////////////////
   // one-hot route decode; bit index = code, open codes give no route

   function [7:0] acc_minus_route;
      input [2:0] code;
      begin
         acc_minus_route = 8'h00;
         if (code != `ACC_NSEL_OPEN)
            acc_minus_route[code] = 1'b1;
      end
   endfunction

   function [7:0] acc_plus_route;
      input [2:0] code;
      input       lcdref_ok;
      begin
         acc_plus_route = 8'h00;
         if (code != 3'h2 && code != 3'h3 &&
             (code != `ACC_PSEL_LCDREF || lcdref_ok))
            acc_plus_route[code] = 1'b1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register storage

   reg [1:0] enable;
   reg [1:0] invert_select;
   reg [1:0] input_deadband_en;
   reg [1:0] align_en;
   reg [1:0] rise_irq_en;
   reg [1:0] fall_irq_en;
   reg [2:0] minus_src_select [0:1];
   reg [2:0] plus_src_select  [0:1];

   wire wr_main1  = WR && ADDR == `ACC_OFS_MAIN1;
   wire wr_main2  = WR && ADDR == `ACC_OFS_MAIN2;
   wire wr_edge1  = WR && ADDR == `ACC_OFS_EDGE1;
   wire wr_edge2  = WR && ADDR == `ACC_OFS_EDGE2;
   wire wr_flags  = WR && ADDR == `ACC_OFS_FLAGS;

   always @(posedge REF_CLK) begin
      if (RESET) begin
         enable               <= 2'b00;
         invert_select        <= 2'b00;
         input_deadband_en    <= 2'b00;
         align_en             <= 2'b00;
         rise_irq_en          <= 2'b00;
         fall_irq_en          <= 2'b00;
         minus_src_select[0]  <= 3'h0;
         minus_src_select[1]  <= 3'h0;
         plus_src_select[0]   <= 3'h0;
         plus_src_select[1]   <= 3'h0;
      end else if (WR) begin
         // only implemented bits are stored
         if (wr_main1) begin
            enable[0]            <= WDATA[`ACC_BIT_ENABLE];
            invert_select[0]     <= WDATA[`ACC_BIT_INVERT];
            input_deadband_en[0] <= WDATA[`ACC_BIT_DEADBAND];
            align_en[0]          <= WDATA[`ACC_BIT_ALIGN];
         end
         if (wr_main2) begin
            enable[1]            <= WDATA[`ACC_BIT_ENABLE];
            invert_select[1]     <= WDATA[`ACC_BIT_INVERT];
            input_deadband_en[1] <= WDATA[`ACC_BIT_DEADBAND];
            align_en[1]          <= WDATA[`ACC_BIT_ALIGN];
         end
         if (wr_edge1) begin
            rise_irq_en[0] <= WDATA[`ACC_BIT_RISE];
            fall_irq_en[0] <= WDATA[`ACC_BIT_FALL];
         end
         if (wr_edge2) begin
            rise_irq_en[1] <= WDATA[`ACC_BIT_RISE];
            fall_irq_en[1] <= WDATA[`ACC_BIT_FALL];
         end
         if (ADDR == `ACC_OFS_MINUS1)
            minus_src_select[0] <= WDATA[2:0];
         if (ADDR == `ACC_OFS_MINUS2)
            minus_src_select[1] <= WDATA[2:0];
         // plus field taken from bits 5-3, the printed field position
         if (ADDR == `ACC_OFS_PLUS1)
            plus_src_select[0] <= WDATA[`ACC_PLUS_LSB+2:`ACC_PLUS_LSB];
         if (ADDR == `ACC_OFS_PLUS2)
            plus_src_select[1] <= WDATA[`ACC_PLUS_LSB+2:`ACC_PLUS_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers; first stage read only by second

   reg [1:0] raw_meta;
   reg [1:0] raw_sync;
   reg       cnt_meta;
   reg       cnt_sync;

   always @(posedge REF_CLK) begin
      if (RESET) begin
         raw_meta <= 2'b00;
         raw_sync <= 2'b00;
         cnt_meta <= 1'b0;
         cnt_sync <= 1'b0;
      end else begin
         raw_meta <= RAW_CMP;
         raw_sync <= raw_meta;
         cnt_meta <= CNT_CLK;
         cnt_sync <= cnt_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // polarity and result capture

   // a disabled core is treated as low, so toggling invert, or toggling enable while the synchronised raw input is high, makes an edge
   wire [1:0] core_out  = raw_sync & enable;
   wire [1:0] polar_out = core_out ^ invert_select;

   reg  [1:0] result;

   always @(posedge REF_CLK) begin
      if (RESET)
         result <= 2'b00;
      else
         result <= polar_out;
   end

   ////////////////////////////////////////////////////////////////////////
   // per-comparator edge flags and output alignment

   wire [1:0] flag_clear = {2{wr_flags}} & WDATA[1:0];
   wire [1:0] unlatched  = (RAW_CMP & enable) ^ invert_select;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_cmp
         acc_edge_flag u_flag (
            .clk         (REF_CLK),
            .rst         (RESET),
            .result      (result[g]),
            .rise_irq_en (rise_irq_en[g]),
            .fall_irq_en (fall_irq_en[g]),
            .clear       (flag_clear[g]),
            .flag        (CMP_IRQ_FLAG[g])
         );
         acc_align u_align (
            .clk          (REF_CLK),
            .rst          (RESET),
            .raw_out      (unlatched[g]),
            .cnt_clk_sync (cnt_sync),
            .align_en     (align_en[g]),
            .aligned_out  (CMP_TO_TIMER[g])
         );
      end
   endgenerate

   assign CMP_TO_PIN   = CMP_TO_TIMER;
   assign CMP_ENABLE   = enable;
   assign CMP_DEADBAND = input_deadband_en;
   // inputs are disconnected while the comparator is off
   assign MINUS_ROUTE1 = enable[0] ? acc_minus_route(minus_src_select[0]) : 8'h00;
   assign MINUS_ROUTE2 = enable[1] ? acc_minus_route(minus_src_select[1]) : 8'h00;
   assign PLUS_ROUTE1  = enable[0] ? acc_plus_route(plus_src_select[0], 1'b0) : 8'h00;
   assign PLUS_ROUTE2  = enable[1] ? acc_plus_route(plus_src_select[1], 1'b1) : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // read port; unmapped addresses and reserved bits read zero

   reg [7:0] next_rdata;

   always @* begin
      next_rdata = `ACC_RESET_BYTE;
      case (ADDR)
         `ACC_OFS_MAIN1: next_rdata = {enable[0], result[0], 1'b0, invert_select[0],
                                       2'b00, input_deadband_en[0], align_en[0]};
         `ACC_OFS_MAIN2: next_rdata = {enable[1], result[1], 1'b0, invert_select[1],
                                       2'b00, input_deadband_en[1], align_en[1]};
         `ACC_OFS_EDGE1:  next_rdata = {6'h00, rise_irq_en[0], fall_irq_en[0]};
         `ACC_OFS_EDGE2:  next_rdata = {6'h00, rise_irq_en[1], fall_irq_en[1]};
         `ACC_OFS_MINUS1: next_rdata = {5'h00, minus_src_select[0]};
         `ACC_OFS_MINUS2: next_rdata = {5'h00, minus_src_select[1]};
         `ACC_OFS_PLUS1:  next_rdata = {2'b00, plus_src_select[0], 3'h0};
         `ACC_OFS_PLUS2:  next_rdata = {2'b00, plus_src_select[1], 3'h0};
         `ACC_OFS_MIRROR: next_rdata = {6'h00, result[1], result[0]};
         `ACC_OFS_FLAGS:  next_rdata = {6'h00, CMP_IRQ_FLAG};
         default:         next_rdata = `ACC_RESET_BYTE;
      endcase
   end

   always @(posedge REF_CLK) begin
      if (RESET)
         RDATA <= `ACC_RESET_BYTE;
      else if (RD)
         RDATA <= next_rdata;
      else
         RDATA <= `ACC_RESET_BYTE;
   end

endmodule // acc_top

// >>> acc_defines.vh
// Purpose: constants for the two-comparator control block
// Assumes: byte-wide registers on a plain address/strobe port
// Notes:   offsets are block-local indices
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

`define ACC_ADDR_W          4
`define ACC_OFS_MAIN1       4'h0
`define ACC_OFS_EDGE1       4'h1
`define ACC_OFS_MINUS1      4'h2
`define ACC_OFS_PLUS1       4'h3
`define ACC_OFS_MAIN2       4'h4
`define ACC_OFS_EDGE2       4'h5
`define ACC_OFS_MINUS2      4'h6
`define ACC_OFS_PLUS2       4'h7
`define ACC_OFS_MIRROR      4'h8
`define ACC_OFS_FLAGS       4'h9

`define ACC_BIT_ENABLE      7
`define ACC_BIT_RESULT      6
`define ACC_BIT_INVERT      4
`define ACC_BIT_DEADBAND    1
`define ACC_BIT_ALIGN       0
`define ACC_BIT_RISE        1
`define ACC_BIT_FALL        0
`define ACC_PLUS_LSB        3

`define ACC_RESET_BYTE      8'h00

`define ACC_SEL_GND         3'h7
`define ACC_SEL_FVR2        3'h6
`define ACC_NSEL_OPEN       3'h5
`define ACC_PSEL_DAC        3'h5
`define ACC_PSEL_LCDREF     3'h4

`endif

// >>> acc_edge_flag.v
// Purpose: edge detector and sticky flag for one comparator
// Assumes: result input already registered on REF_CLK
// Notes:   set wins over a simultaneous clear
`timescale 1ns/1ps
module acc_edge_flag (
   input  wire clk,
   input  wire rst,
   input  wire result,
   input  wire rise_irq_en,
   input  wire fall_irq_en,
   input  wire clear,
   output reg  flag
);
   reg  prev;
   wire rise_evt = result & ~prev;
   wire fall_evt = ~result & prev;
   wire set_evt  = (rise_evt & rise_irq_en) | (fall_evt & fall_irq_en);

   always @(posedge clk) begin
      if (rst) begin
         prev <= 1'b0;
         flag <= 1'b0;
      end else begin
         prev <= result;
         if (set_evt)
            flag <= 1'b1;
         else if (clear)
            flag <= 1'b0;
      end
   end
endmodule // acc_edge_flag

// >>> acc_align.v
// Purpose: optional alignment of a comparator output to the counter clock
// Assumes: counter clock (post-prescale) already synchronised to REF_CLK
// Notes:   unaligned path is combinational by intent
`timescale 1ns/1ps
module acc_align (
   input  wire clk,
   input  wire rst,
   input  wire raw_out,
   input  wire cnt_clk_sync,
   input  wire align_en,
   output wire aligned_out
);
   reg cnt_clk_d;
   reg held;
   wire cnt_fall = cnt_clk_d & ~cnt_clk_sync;

   always @(posedge clk) begin
      if (rst) begin
         cnt_clk_d <= 1'b0;
         held      <= 1'b0;
      end else begin
         cnt_clk_d <= cnt_clk_sync;
         if (cnt_fall)
            held <= raw_out;
      end
   end

   // no latch when alignment is off, so the pin sees the comparator directly
   assign aligned_out = align_en ? held : raw_out;
endmodule // acc_align

// >>> acc_top_sva.sv
// Purpose: port checks for acc_top
// Assumes: strobes one cycle long, never together
// Notes:   shadows the first main and edge bytes from writes
`timescale 1ns/1ps
`include "acc_defines.vh"
module acc_top_sva (
   input wire                   REF_CLK,
   input wire                   RESET,
   input wire [`ACC_ADDR_W-1:0] ADDR,
   input wire [7:0]             WDATA,
   input wire                   WR,
   input wire                   RD,
   input wire [7:0]             RDATA,
   input wire [1:0]             RAW_CMP,
   input wire                   CNT_CLK,
   input wire [1:0]             CMP_ENABLE,
   input wire [1:0]             CMP_DEADBAND,
   input wire [1:0]             CMP_TO_TIMER,
   input wire [1:0]             CMP_TO_PIN,
   input wire [1:0]             CMP_IRQ_FLAG,
   input wire [7:0]             MINUS_ROUTE1,
   input wire [7:0]             MINUS_ROUTE2,
   input wire [7:0]             PLUS_ROUTE1,
   input wire [7:0]             PLUS_ROUTE2
);
   reg  [7:0] m1;
   reg  [1:0] e1;
   reg  [3:0] quiet;
   wire       clr1 = WR && ADDR == `ACC_OFS_FLAGS && WDATA[0];
   wire       wm1  = WR && ADDR == `ACC_OFS_MAIN1;
   // quiet counts counter-clock high cycles; sync delay needs several
   always @(posedge REF_CLK) begin
      if (RESET) begin
         m1 <= 8'h00;
         e1 <= 2'b00;
         quiet <= 4'h0;
      end else begin
         if (wm1) m1 <= WDATA;
         if (WR && ADDR == `ACC_OFS_EDGE1) e1 <= WDATA[1:0];
         quiet <= (!CNT_CLK || wm1) ? 4'h0 : (quiet == 4'hF) ? quiet : quiet + 4'h1;
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   sequence rd_mirror;
      RD && ADDR == `ACC_OFS_MIRROR;
   endsequence
   sequence wr_main2;
      WR && ADDR == `ACC_OFS_MAIN2;
   endsequence
   chk_enable_write: assert property (wm1 |=> CMP_ENABLE[0] == $past(WDATA[7]))
      else $error("enable not taken from write");
   chk_deadband_write: assert property (wr_main2 |=> CMP_DEADBAND[1] == $past(WDATA[1]))
      else $error("deadband not taken from write");
   chk_unaligned_path: assert property (!m1[0] |-> CMP_TO_PIN[0] == ((RAW_CMP[0] & m1[7]) ^ m1[4]))
      else $error("unaligned output wrong");
   chk_aligned_hold: assert property (m1[0] && quiet >= 4'h6 |-> $stable(CMP_TO_PIN[0]))
      else $error("aligned output moved without counter fall");
   chk_pin_timer: assert property (CMP_TO_PIN == CMP_TO_TIMER)
      else $error("pin and timer outputs differ");
   chk_mirror_zero: assert property (rd_mirror |=> RDATA[7:2] == 6'h00)
      else $error("mirror upper bits not zero");
   chk_flag_sticky: assert property (CMP_IRQ_FLAG[0] && !clr1 |=> CMP_IRQ_FLAG[0])
      else $error("flag dropped without clear");
   chk_flag_cause: assert property ($rose(CMP_IRQ_FLAG[0]) |-> $past(e1) != 2'b00)
      else $error("flag set with no edge enabled");
   chk_route_off: assert property (!CMP_ENABLE[0] |-> (MINUS_ROUTE1 | PLUS_ROUTE1) == 8'h00)
      else $error("route active while disabled");
   chk_route_legal: assert property ($onehot0(MINUS_ROUTE2) && !MINUS_ROUTE1[5]
         && PLUS_ROUTE1[4:2] == 3'b000 && PLUS_ROUTE2[3:2] == 2'b00)
      else $error("illegal route");
endmodule // acc_top_sva
bind acc_top acc_top_sva acc_top_sva_inst (.REF_CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA,
   .RAW_CMP, .CNT_CLK, .CMP_ENABLE, .CMP_DEADBAND, .CMP_TO_TIMER, .CMP_TO_PIN, .CMP_IRQ_FLAG,
   .MINUS_ROUTE1, .MINUS_ROUTE2, .PLUS_ROUTE1, .PLUS_ROUTE2);

// >>> acc_analog_model.sv
// Purpose: analog cores and counter clock beside acc_top
// Assumes: plus_gt high means plus node above minus node
// Notes:   counter clock idles high between bursts
`timescale 1ns/1ps
module acc_analog_model (
   input  wire [1:0] cmp_enable,
   input  wire [1:0] plus_gt,
   input  wire       cnt_run,
   output wire [1:0] raw_cmp,
   output reg        cnt_clk
);
   // a core that is off draws nothing and drives low
   assign raw_cmp = plus_gt & cmp_enable;
   // post-prescale clock, period unrelated to the system clock
   initial begin
      cnt_clk = 1'b1;
      forever begin
         #73;
         if (cnt_run || !cnt_clk) cnt_clk = ~cnt_clk;
      end
   end
endmodule // acc_analog_model

// >>> testbench.sv
// Purpose: self-checking bench for acc_top
// Assumes: register offsets 0..9, flag register at 9
// Notes:   result path is four clocks from raw to flag
`timescale 1ns/1ps
module testbench;
   reg        clk;
   reg        rst;
   reg  [3:0] addr;
   reg  [7:0] wdata;
   reg        wr;
   reg        rd;
   reg  [1:0] plus_gt;
   reg        cnt_run;
   wire [7:0] rdata, mr1, mr2, pr1, pr2;
   wire [1:0] raw, en, db, tmr, pin, flag;
   wire       cnt_clk;
   integer    errors;
   integer    checks;
   integer    i;
   acc_top acc_top_inst (.REF_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .RAW_CMP(raw), .CNT_CLK(cnt_clk), .CMP_ENABLE(en),
      .CMP_DEADBAND(db), .CMP_TO_TIMER(tmr), .CMP_TO_PIN(pin), .CMP_IRQ_FLAG(flag),
      .MINUS_ROUTE1(mr1), .MINUS_ROUTE2(mr2), .PLUS_ROUTE1(pr1), .PLUS_ROUTE2(pr2));
   acc_analog_model acc_analog_model_inst (.cmp_enable(en), .plus_gt(plus_gt),
      .cnt_run(cnt_run), .raw_cmp(raw), .cnt_clk(cnt_clk));
   ////////////////////////////////////////
   task cmp(input [7:0] got, input [7:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wrr(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk);
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rdc(input [3:0] a, input [7:0] e);
      begin
         @(posedge clk);
         rd <= 1'b1;
         addr <= a;
         @(posedge clk);
         rd <= 1'b0;
         #1 cmp(rdata, e);
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task edge_step(input [7:0] main, input [7:0] e);
      begin
         wrr(4'h0, main);
         tick(5);
         rdc(4'h9, e);
      end
   endtask
   task finish_test;
      begin
         $display("checks=%0d errors=%0d", checks, errors);
         if (errors == 0 && checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   ////////////////////////////////////////
   task t_reset;
      begin
         cmp({flag, en, db, pin}, 8'h00);
         for (i = 0; i < 16; i = i + 1) rdc(i[3:0], 8'h00);
         $display("reset test done");
      end
   endtask
   task t_regs;
      begin
         wrr(4'h0, 8'h6E);
         rdc(4'h0, 8'h02);
         wrr(4'h4, 8'h02);
         tick(1);
         cmp({6'h00, db}, 8'h03);
         wrr(4'h1, 8'hFF);
         rdc(4'h1, 8'h03);
         wrr(4'h6, 8'hFF);
         rdc(4'h6, 8'h07);
         wrr(4'h3, 8'hFF);
         rdc(4'h3, 8'h38);
         wrr(4'h8, 8'hFF);
         rdc(4'h8, 8'h00);
         wrr(4'hC, 8'hFF);
         rdc(4'hC, 8'h00);
         $display("register test done");
      end
   endtask
   task t_polarity;
      begin
         @(posedge clk);
         plus_gt <= 2'b01;
         wrr(4'h0, 8'h80);
         tick(5);
         cmp({6'h00, pin}, 8'h01);
         rdc(4'h0, 8'hC0);
         rdc(4'h8, 8'h01);
         wrr(4'h0, 8'h90);
         tick(1);
         cmp({6'h00, tmr}, 8'h00);
         tick(4);
         rdc(4'h0, 8'h90);
         @(posedge clk);
         plus_gt <= 2'b11;
         wrr(4'h4, 8'h80);
         tick(5);
         rdc(4'h8, 8'h02);
         wrr(4'h0, 8'h00);
         wrr(4'h4, 8'h00);
         plus_gt <= 2'b00;
         $display("polarity test done");
      end
   endtask
   task t_edges;
      begin
         wrr(4'h1, 8'h02);
         tick(5);
         wrr(4'h9, 8'h03);
         rdc(4'h9, 8'h00);
         edge_step(8'h10, 8'h01);
         rdc(4'h9, 8'h01);
         wrr(4'h9, 8'h01);
         rdc(4'h9, 8'h00);
         edge_step(8'h00, 8'h00);
         wrr(4'h1, 8'h01);
         edge_step(8'h10, 8'h00);
         edge_step(8'h00, 8'h01);
         cmp({6'h00, flag}, 8'h01);
         wrr(4'h9, 8'h01);
         // back to back: the clear lands in the very cycle the rise sets the flag
         wrr(4'h1, 8'h03);
         wrr(4'h0, 8'h10);
         wrr(4'h9, 8'h01);
         rdc(4'h9, 8'h01);
         wrr(4'h9, 8'h01);
         $display("edge test done");
      end
   endtask
   task t_routes;
      begin
         wrr(4'h0, 8'h80);
         wrr(4'h4, 8'h80);
         for (i = 0; i < 8; i = i + 1) begin
            wrr(4'h2, i[7:0]);
            wrr(4'h6, i[7:0]);
            wrr(4'h3, {i[4:0], 3'b000});
            wrr(4'h7, {i[4:0], 3'b000});
            tick(1);
            cmp(mr1, (i == 5) ? 8'h00 : 8'h01 << i);
            cmp(mr2, (i == 5) ? 8'h00 : 8'h01 << i);
            cmp(pr1, (i > 1 && i < 5) ? 8'h00 : 8'h01 << i);
            cmp(pr2, (i == 2 || i == 3) ? 8'h00 : 8'h01 << i);
         end
         wrr(4'h0, 8'h00);
         tick(1);
         cmp(mr1 | pr1, 8'h00);
         $display("route test done");
      end
   endtask
   task t_align;
      begin
         wrr(4'h0, 8'h81);
         @(posedge clk);
         plus_gt <= 2'b01;
         tick(10);
         cmp({6'h00, pin}, 8'h00);
         cnt_run <= 1'b1;
         @(negedge cnt_clk);
         @(posedge clk);
         cnt_run <= 1'b0;
         tick(6);
         cmp({6'h00, tmr}, 8'h01);
         @(posedge clk);
         plus_gt <= 2'b00;
         tick(10);
         cmp({6'h00, pin}, 8'h01);
         wrr(4'h0, 8'h80);
         tick(1);
         cmp({6'h00, pin}, 8'h00);
         $display("align test done");
      end
   endtask
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors = errors + 1;
      finish_test;
   end
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      plus_gt = 2'b00;
      cnt_run = 1'b0;
      errors = 0;
      checks = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_regs;
      t_polarity;
      t_edges;
      t_routes;
      t_align;
      finish_test;
   end
endmodule // testbench
